/* File: hw/osd_device.sv */
// Purpose: switch-side serial slave with output latches and health bits
// Assumes: link pins asynchronous to clk_i, synchronised here; sense inputs from analog comparators
// Notes: analog protection not modelled
`timescale 1ns/10ps
`include "osd_params.svh"
module osd_device
   import osd_pkg::*;
(
   // system
   input wire logic clk_i,
   input wire logic reset_i,
   // link
   osd_link_if.device link,
   // device pins
   input wire logic reset_n_i,
   input wire logic openload_detect_enable_i,
   input wire logic [`OSD_NPAR-1:0] parallel_drive_in_i,
   input wire logic [`OSD_NCH-1:0] detect_threshold_i,
   // outputs
   output logic [`OSD_NCH-1:0] channel_on_o,
   output logic [`OSD_NCH-1:0] channel_health_bit_o
);
   // synchronisers
   logic [1:0] cs_s_r;
   logic [1:0] sck_s_r;
   logic [1:0] si_s_r;
   logic [1:0] rst_s_r;
   logic [1:0] ol_s_r;
   logic [`OSD_NPAR-1:0] par_s1_r;
   logic [`OSD_NPAR-1:0] par_s2_r;
   logic [`OSD_NCH-1:0] vth_s1_r;
   logic [`OSD_NCH-1:0] vth_s2_r;
   // edge detect
   logic cs_d_r;
   logic sck_d_r;
   // shifter and latches
   osd_byte_t shift_r;
   osd_byte_t ctrl_r;
   osd_byte_t health_r;
   osd_byte_t out_r;
   osd_byte_t hbit_r;
   logic [`OSD_BITCNT_W-1:0] cnt_r;
   // pin drivers
   logic so_d_r;
   logic so_oe_n_r;
   logic alert_oe_n_r;
   // per-channel status
   wire [`OSD_NCH-1:0] open_flt;
   wire [`OSD_NCH-1:0] over_flt;
   wire [`OSD_NCH-1:0] fault_now;
   wire [`OSD_NCH-1:0] health_live;
   always_ff @(posedge clk_i) begin
      cs_s_r <= {cs_s_r[0], link.chip_select_n};
   end
   always_ff @(posedge clk_i) begin
      sck_s_r <= {sck_s_r[0], link.shift_clock};
   end
   always_ff @(posedge clk_i) begin
      si_s_r <= {si_s_r[0], link.serial_in};
   end
   always_ff @(posedge clk_i) begin
      rst_s_r <= {rst_s_r[0], reset_n_i};
   end
   always_ff @(posedge clk_i) begin
      ol_s_r <= {ol_s_r[0], openload_detect_enable_i};
   end
   always_ff @(posedge clk_i) begin
      par_s1_r <= parallel_drive_in_i;
      par_s2_r <= par_s1_r;
   end
   always_ff @(posedge clk_i) begin
      vth_s1_r <= detect_threshold_i;
      vth_s2_r <= vth_s1_r;
   end
   wire cs_n = cs_s_r[1];
   wire sck = sck_s_r[1];
   wire din = si_s_r[1];
   wire ol_en = ol_s_r[1];
   wire pin_rst = ~rst_s_r[1];
   wire clr = reset_i | pin_rst;
   wire cs_fall = cs_d_r & ~cs_n;
   wire cs_rise = ~cs_d_r & cs_n;
   wire sck_fall = ~cs_n & sck_d_r & ~sck;
   wire sck_rise = ~cs_n & ~sck_d_r & sck;
   wire xfer_ok = (cnt_r == `OSD_XFER_BITS);
   wire cnt_full = &cnt_r;
   wire [`OSD_NCH-1:0] par_ext = {{(`OSD_NCH-`OSD_NPAR){1'b0}}, par_s2_r};
   wire [`OSD_NCH-1:0] drive_on = ctrl_r | par_ext;
   // threshold bit high means output voltage above threshold
   for (genvar ch = 0; ch < `OSD_NCH; ch++) begin : g_chan
      wire ch_on = drive_on[ch];
      wire ch_high = vth_s2_r[ch];
      assign open_flt[ch] = ~ch_on & ~ch_high & ol_en;
      assign over_flt[ch] = ch_on & ch_high;
      assign fault_now[ch] = open_flt[ch] | over_flt[ch];
      // serial bit when healthy, inverted on fault
      assign health_live[ch] = ctrl_r[ch] ^ (fault_now[ch] | health_r[ch]);
   end
   wire any_fault = |(fault_now | health_r);
   wire [`OSD_BITCNT_W-1:0] cnt_step = cnt_full ? cnt_r : cnt_r + 4'h1;
   wire [`OSD_NCH-1:0] shift_in = {shift_r[6:0], din};
   wire [`OSD_NCH-1:0] shift_nxt = cs_fall ? health_live : (sck_fall ? shift_in : shift_r);
   wire [`OSD_BITCNT_W-1:0] cnt_nxt = cs_fall ? 4'h0 : (sck_fall ? cnt_step : cnt_r);
   // fault latch, set wins over clear
   wire [`OSD_NCH-1:0] health_nxt = cs_rise ? fault_now : (health_r | fault_now);
   wire [`OSD_NCH-1:0] ctrl_nxt = (cs_rise && xfer_ok) ? shift_r : ctrl_r;
   wire so_d_nxt = cs_fall ? health_live[7] : (sck_rise ? shift_r[7] : so_d_r);
   wire so_oe_n_nxt = cs_n ? 1'b1 : (cs_fall ? 1'b0 : so_oe_n_r);
   wire alert_oe_n_nxt = ~any_fault;
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         cs_d_r <= 1'b1;
      end else begin
         cs_d_r <= cs_n;
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sck_d_r <= 1'b0;
      end else begin
         sck_d_r <= sck;
      end
   end
   always_ff @(posedge clk_i) begin
      if (clr) begin
         health_r <= `OSD_HEALTH_RST;
      end else begin
         health_r <= health_nxt;
      end
   end
   always_ff @(posedge clk_i) begin
      if (clr) begin
         shift_r <= `OSD_CTRL_RST;
      end else begin
         shift_r <= shift_nxt;
      end
   end
   always_ff @(posedge clk_i) begin
      if (clr) begin
         cnt_r <= 4'h0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end
   always_ff @(posedge clk_i) begin
      if (clr) begin
         ctrl_r <= `OSD_CTRL_RST;
      end else begin
         ctrl_r <= ctrl_nxt;
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         so_d_r <= 1'b1;
      end else begin
         so_d_r <= so_d_nxt;
      end
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         so_oe_n_r <= 1'b1;
      end else begin
         so_oe_n_r <= so_oe_n_nxt;
      end
   end
   always_ff @(posedge clk_i) begin
      if (clr) begin
         out_r <= 8'h00;
      end else begin
         out_r <= drive_on;
      end
   end
   always_ff @(posedge clk_i) begin
      if (clr) begin
         alert_oe_n_r <= 1'b1;
      end else begin
         alert_oe_n_r <= alert_oe_n_nxt;
      end
   end
   always_ff @(posedge clk_i) begin
      if (clr) begin
         hbit_r <= 8'h00;
      end else begin
         hbit_r <= health_live;
      end
   end
   assign channel_on_o = out_r;
   assign channel_health_bit_o = hbit_r;
   assign link.serial_out_d = so_d_r;
   assign link.serial_out_oe_n = so_oe_n_r;
   assign link.alert_d = 1'b0;
   assign link.alert_oe_n = alert_oe_n_r;
endmodule // osd_device

/* File: hw/osd_params.svh */
// Purpose: constants for the octal switch serial link
// Assumes: included by both ends
// Notes: timing counts in system clock cycles
`ifndef OSD_PARAMS_SVH
`define OSD_PARAMS_SVH
`define OSD_NCH 8
`define OSD_NPAR 4
`define OSD_BITCNT_W 4
`define OSD_XFER_BITS 4'h8
`define OSD_CLK_MHZ 100
`define OSD_HALF_NS 80
`define OSD_HALF_CYC ((`OSD_HALF_NS * `OSD_CLK_MHZ + 999) / 1000)
`define OSD_SETTLE_US 200
`define OSD_SETTLE_CYC (`OSD_SETTLE_US * `OSD_CLK_MHZ)
`define OSD_GAP_CYC 8
`define OSD_CTRL_RST 8'h00
`define OSD_HEALTH_RST 8'h00
`endif

/* File: hw/osd_pkg.sv */
// Purpose: shared types for the octal switch serial link
// Assumes: nothing
// Notes: types only
package osd_pkg;
   typedef logic [7:0] osd_byte_t;
   typedef enum logic [2:0] {OSD_IDLE, OSD_LEAD, OSD_LOW, OSD_HIGH, OSD_LAG, OSD_WAIT} osd_hstate_t;
endpackage

/* File: hw/osd_link_if.sv */
// Purpose: serial link between host and octal switch
// Assumes: open-drain alert resolved here
// Notes: oe low means driving
`timescale 1ns/10ps
interface osd_link_if;
   logic chip_select_n;
   logic shift_clock;
   logic serial_in;
   logic serial_out_d;
   logic serial_out_oe_n;
   logic serial_out;
   logic alert_d;
   logic alert_oe_n;
   logic error_alert_n;
   assign serial_out = serial_out_oe_n ? 1'b1 : serial_out_d;
   assign error_alert_n = alert_oe_n ? 1'b1 : alert_d;
   modport device (input chip_select_n, input shift_clock, input serial_in,
      output serial_out_d, output serial_out_oe_n, output alert_d, output alert_oe_n);
   modport host (output chip_select_n, output shift_clock, output serial_in,
      input serial_out, input error_alert_n);
endinterface

/* File: hw/osd_host.sv */
// Purpose: host-side serial master for the octal switch
// Assumes: one byte per request
// Notes: shift clock made by a divider
`timescale 1ns/10ps
`include "osd_params.svh"
module osd_host
   import osd_pkg::*;
(
   // system
   input wire logic clk_i,
   input wire logic reset_i,
   // link
   osd_link_if.host link,
   // user
   input wire logic start_i,
   input wire logic diag_i,
   input wire logic [7:0] ctrl_i,
   output logic busy_o,
   output logic done_o,
   output logic [7:0] health_o,
   output logic alert_o
);
   osd_hstate_t st_r;
   logic [15:0] tmr_r;
   logic [3:0] bit_r;
   logic pass_r, diag_r, cs_r, sck_r, si_r, done_r, busy_r;
   osd_byte_t tx_r, rx_r, hl_r;
   logic [1:0] so_s_r, al_s_r;
   logic alert_r;
   wire tmr_zero = (tmr_r == 16'h0000);
   always_ff @(posedge clk_i) begin
      so_s_r <= {so_s_r[0], link.serial_out};
      al_s_r <= {al_s_r[0], link.error_alert_n};
      alert_r <= ~al_s_r[1];
   end
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         st_r <= OSD_IDLE;
         tmr_r <= '0;
         bit_r <= '0;
         pass_r <= 1'b0;
         diag_r <= 1'b0;
         cs_r <= 1'b1;
         sck_r <= 1'b0;
         si_r <= 1'b0;
         done_r <= 1'b0;
         busy_r <= 1'b0;
         tx_r <= '0;
         rx_r <= '0;
         hl_r <= '0;
      end else begin
         done_r <= 1'b0;
         if (!tmr_zero) begin
            tmr_r <= tmr_r - 16'h0001;
         end
         case (st_r)
            OSD_IDLE: if (start_i) begin
               tx_r <= ctrl_i;
               diag_r <= diag_i;
               pass_r <= 1'b0;
               busy_r <= 1'b1;
               st_r <= OSD_LEAD;
            end
            OSD_LEAD: begin
               cs_r <= 1'b0;
               si_r <= tx_r[7];
               bit_r <= '0;
               tmr_r <= 16'(`OSD_HALF_CYC * 2);
               st_r <= OSD_HIGH;
            end
            OSD_HIGH: if (tmr_zero) begin
               sck_r <= 1'b1;
               si_r <= tx_r[7];
               tmr_r <= 16'(`OSD_HALF_CYC);
               st_r <= OSD_LOW;
            end
            OSD_LOW: if (tmr_zero) begin
               sck_r <= 1'b0;
               rx_r <= {rx_r[6:0], so_s_r[1]};
               tx_r <= {tx_r[6:0], tx_r[7]};
               bit_r <= bit_r + 4'h1;
               tmr_r <= 16'(`OSD_HALF_CYC);
               st_r <= (bit_r == 4'h7) ? OSD_LAG : OSD_HIGH;
            end
            OSD_LAG: if (tmr_zero) begin
               cs_r <= 1'b1;
               if (diag_r && !pass_r) begin
                  pass_r <= 1'b1;
                  tmr_r <= 16'(`OSD_SETTLE_CYC);
                  st_r <= OSD_WAIT;
               end else begin
                  hl_r <= rx_r;
                  done_r <= 1'b1;
                  busy_r <= 1'b0;
                  tmr_r <= 16'(`OSD_GAP_CYC);
                  st_r <= OSD_WAIT;
               end
            end
            OSD_WAIT: if (tmr_zero) begin
               st_r <= busy_r ? OSD_LEAD : OSD_IDLE;
            end
            default: st_r <= OSD_IDLE;
         endcase
      end
   end
   assign link.chip_select_n = cs_r;
   assign link.shift_clock = sck_r;
   assign link.serial_in = si_r;
   assign busy_o = busy_r;
   assign done_o = done_r;
   assign health_o = hl_r;
   assign alert_o = alert_r;
endmodule // osd_host

/* File: verif/osd_link_props.sv */
// Purpose: protocol checks on the host to device link
// Assumes: host and device ends joined by one link
// Notes: pins seen through clk_i
`timescale 1ns/10ps
module osd_link_props (
   // system
   input wire logic clk_i,
   input wire logic reset_i,
   // link
   input wire logic chip_select_n,
   input wire logic shift_clock,
   input wire logic serial_in,
   input wire logic serial_out_oe_n,
   input wire logic serial_out,
   input wire logic error_alert_n
);
   logic sck_r;
   logic [3:0] rises_r;
   wire sck_up = shift_clock & ~sck_r;
   always_ff @(posedge clk_i) begin
      sck_r <= shift_clock;
      rises_r <= (reset_i | chip_select_n) ? 4'h0 : rises_r + {3'h0, sck_up};
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   property p_cnt; $rose(chip_select_n) |-> rises_r == 4'h8; endproperty
   a_cnt: assert property (p_cnt) else $error("clock count wrong");
   property p_quiet; $changed(chip_select_n) |-> !shift_clock && !$past(shift_clock); endproperty
   a_quiet: assert property (p_quiet) else $error("clock high at select edge");
   property p_drive; $fell(chip_select_n) |-> ##[1:6] !serial_out_oe_n; endproperty
   a_drive: assert property (p_drive) else $error("output not driven");
   property p_free; $rose(chip_select_n) |-> ##[1:6] serial_out_oe_n; endproperty
   a_free: assert property (p_free) else $error("output not released");
   property p_idle; chip_select_n [*8] |-> serial_out; endproperty
   a_idle: assert property (p_idle) else $error("output active while idle");
   property p_si; shift_clock && $past(shift_clock) |-> $stable(serial_in); endproperty
   a_si: assert property (p_si) else $error("data moved while clock high");
   property p_hold; $fell(shift_clock) |-> $stable(serial_in) [*4]; endproperty
   a_hold: assert property (p_hold) else $error("data moved near clock fall");
   property p_so; $fell(shift_clock) |-> $stable(serial_out) [*4]; endproperty
   a_so: assert property (p_so) else $error("output moved near clock fall");
   property p_alert; $rose(error_alert_n) |-> chip_select_n; endproperty
   a_alert: assert property (p_alert) else $error("alert left mid frame");
endmodule // osd_link_props

/* File: verif/octal_switch_spi_diag_test.sv */
// Purpose: bench for both link ends
// Assumes: second device driven by the bench
// Notes: host results queued, checked on done_o
`timescale 1ns/10ps
module octal_switch_spi_diag_test
   import osd_pkg::*;
;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic start_i = 1'b0;
   logic diag_i = 1'b0;
   logic rst_n = 1'b1;
   logic ole = 1'b0;
   logic busy_o, done_o, alert_o;
   logic [3:0] par = 4'h0;
   osd_byte_t ctrl_i = 8'h00;
   osd_byte_t thr = 8'h00;
   osd_byte_t cur = 8'h00;
   osd_byte_t health_o, on1, hb1, on2, so, r;
   logic [15:0] q[$];
   logic [15:0] ex;
   int seed = 3944;
   int error_cnt = 0;
   int tests_run = 0;
   osd_link_if lk ();
   osd_link_if lk2 ();
   osd_host osd_host_inst (.clk_i(clk_i), .reset_i(reset_i), .link(lk), .start_i(start_i), .diag_i(diag_i),
      .ctrl_i(ctrl_i), .busy_o(busy_o), .done_o(done_o), .health_o(health_o), .alert_o(alert_o));
   osd_device osd_device_inst (.clk_i(clk_i), .reset_i(reset_i), .link(lk), .reset_n_i(rst_n),
      .openload_detect_enable_i(ole), .parallel_drive_in_i(par), .detect_threshold_i(thr),
      .channel_on_o(on1), .channel_health_bit_o(hb1));
   osd_device osd_device_inst2 (.clk_i(clk_i), .reset_i(reset_i), .link(lk2), .reset_n_i(1'b1),
      .openload_detect_enable_i(1'b0), .parallel_drive_in_i(4'h0), .detect_threshold_i(8'h00),
      .channel_on_o(on2), .channel_health_bit_o());
   osd_link_props osd_link_props_inst (.clk_i(clk_i), .reset_i(reset_i), .chip_select_n(lk.chip_select_n),
      .shift_clock(lk.shift_clock), .serial_in(lk.serial_in), .serial_out_oe_n(lk.serial_out_oe_n),
      .serial_out(lk.serial_out), .error_alert_n(lk.error_alert_n));
   initial forever #5 clk_i = ~clk_i;
   task automatic chk(input string nm, input osd_byte_t e, input osd_byte_t g);
      tests_run++;
      if (g !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic run(input osd_byte_t c, input logic d, input osd_byte_t f);
      int n = 0;
      start_i = 1'b1;
      ctrl_i = c;
      diag_i = d;
      q.push_back({(d ? c : cur) ^ f, c | {4'h0, par}});
      @(negedge clk_i);
      start_i = 1'b0;
      while (done_o !== 1'b1 && n < 30000) begin
         @(negedge clk_i);
         n++;
      end
      if (n == 30000) begin
         error_cnt++;
         wrap_up();
      end
      repeat (12) @(negedge clk_i);
      cur = c;
   endtask
   task automatic flt(input osd_byte_t t, input logic o);
      osd_byte_t on, f;
      on = cur | {4'h0, par};
      f = (t & on) | (o ? ~(t | on) : 8'h00);
      thr = t;
      ole = o;
      repeat (8) @(negedge clk_i);
      chk("alert", {7'h00, |f}, {7'h00, alert_o});
      chk("live health", cur ^ f, hb1);
      run(cur, 1'b0, f);
      thr = 8'h00;
      ole = 1'b0;
      run(cur, 1'b0, f);
      run(cur, 1'b0, 8'h00);
      chk("alert clear", 8'h00, {7'h00, alert_o});
   endtask
   task automatic xfer2(input osd_byte_t d, input int n);
      lk2.chip_select_n = 1'b0;
      repeat (8) @(negedge clk_i);
      for (int i = 0; i < n; i++) begin
         lk2.serial_in = d[7 - i % 8];
         repeat (4) @(negedge clk_i);
         lk2.shift_clock = 1'b1;
         repeat (8) @(negedge clk_i);
         so = {so[6:0], lk2.serial_out};
         lk2.shift_clock = 1'b0;
         repeat (4) @(negedge clk_i);
      end
      lk2.serial_in = ~lk2.serial_in;
      repeat (4) @(negedge clk_i);
      lk2.chip_select_n = 1'b1;
      repeat (16) @(negedge clk_i);
   endtask
   always @(negedge clk_i) begin
      if (done_o === 1'b1) begin
         ex = q.pop_front();
         chk("health", ex[15:8], health_o);
         repeat (6) @(negedge clk_i);
         chk("channel on", ex[7:0], on1);
      end
   end
   initial begin
      lk2.chip_select_n = 1'b1;
      lk2.shift_clock = 1'b0;
      lk2.serial_in = 1'b0;
      repeat (12) @(negedge clk_i);
      reset_i = 1'b0;
      repeat (4) @(negedge clk_i);
      for (int k = 0; k < 6; k++) begin
         par = 4'($random(seed));
         run(8'($random(seed)), 1'b0, 8'h00);
      end
      par = 4'h5;
      run(8'h0C, 1'b0, 8'h00);
      flt(8'hFF, 1'b0);
      flt(8'h00, 1'b1);
      run(8'($random(seed)), 1'b1, 8'h00);
      rst_n = 1'b0;
      repeat (8) @(negedge clk_i);
      chk("reset outputs", 8'h00, on1);
      rst_n = 1'b1;
      repeat (8) @(negedge clk_i);
      cur = 8'h00;
      run(8'h81, 1'b0, 8'h00);
      cur = 8'h00;
      for (int k = 0; k < 3; k++) begin
         r = 8'($random(seed));
         xfer2(r, 8);
         chk("shifted out", cur, so);
         chk("serial on", r, on2);
         cur = r;
      end
      xfer2(~r, 7);
      chk("short frame", r, on2);
      xfer2(~r, 9);
      chk("long frame", r, on2);
      repeat (4) begin
         lk2.serial_in = ~lk2.serial_in;
         lk2.shift_clock = 1'b1;
         repeat (4) @(negedge clk_i);
         lk2.shift_clock = 1'b0;
         repeat (4) @(negedge clk_i);
      end
      chk("ignored", r, on2);
      chk("released", 8'h01, {7'h00, lk2.serial_out});
      wrap_up();
   end
endmodule // octal_switch_spi_diag_test
